// ---- logic/tlt_translate.sv ----
// Functional notes
// - fetch first-level buffer: 32 entries, fully associative, 4KB mappings only.
// - larger pages refill first level as one 4K entry covering the access.
// - fetch hit answers next cycle with address; permission failure gives fetch abort.
// - load and store each own a 32-entry fully associative 4KB buffer.
// - load/store hit answers next cycle; permission failure gives data abort.
// - all first-level misses go to one 512-entry four-way second level.
// - second level holds 4K, 64K, 1M, 16M, 2M and 1G pages.
// - second-level latency varies with arbitration, maintenance and page sizes.
// - no entry can be locked against replacement.
// - entries hold address, size, physical address, type, permissions and tags.
// - address bits 31 down to page log2 must equal stored address.
// - security tag and hypervisor bit must equal the request's.
// - address-space tag must equal current one unless entry is global.
// - virtual-machine tag must equal current stage-2 identifier.
// - hypervisor skips both tag compares; secure skips the vm compare.
// - first level, then second level, then table walk on second miss.
// - walk format follows long select of the request's security state.
// - write-back walk cacheability reads via data cache, otherwise external.
// - disabled walk for the chosen base gives a translation fault.
// - failing permissions or domain on a match raises an abort; a manager domain in short format skips the permission check.
// - a match supplies physical address and region attributes.
`timescale 1ns/100ps
module tlt_translate
    import tlt_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [NCH-1:0] req_valid_in,
    input wire tlt_req_s [NCH-1:0] req_in,
    output logic [NCH-1:0] req_ready_out,
    output tlt_resp_s [NCH-1:0] resp_out,
    output logic walk_req_out,
    output logic [31:0] walk_va_out,
    output logic walk_cached_out,
    output logic walk_long_out,
    output logic walk_base1_out,
    input wire logic walk_done_in,
    input wire logic walk_fault_in,
    input wire tlt_walk_s walk_entry_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out
);
    tlt_state_s s;
    tlt_state_s next_s;
    logic [NCH-1:0] l1_hit;
    tlt_entry_s [NCH-1:0] l1_e;
    tlt_req_s cur;
    tlt_ctrl_s cctl;
    logic l2_hit;
    tlt_entry_s l2_e;
    logic [L2_IDX_W-1:0] pidx;
    logic walk_off;
    logic base1;
    logic fin;
    logic fin_fault;
    tlt_entry_s fin_e;
    tlt_entry_s new_e;
    tlt_resp_s fin_r;

    // assertions below run on the block clock, off during reset
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    // log2 of the page size
    function automatic logic [4:0] size_shift(input tlt_size_e sz);
        case (sz)
            SZ_64K: return SHIFT_64K;
            SZ_1M: return SHIFT_1M;
            SZ_2M: return SHIFT_2M;
            SZ_16M: return SHIFT_16M;
            SZ_1G: return SHIFT_1G;
            default: return SHIFT_4K;
        endcase
    endfunction : size_shift

    // page-number bits that take part in the compare
    function automatic logic [VPN_W-1:0] size_mask(input tlt_size_e sz);
        logic [4:0] lo;
        lo = 5'(size_shift(sz) - SHIFT_4K);
        return ~((VPN_W'(1) << lo) - VPN_W'(1));
    endfunction : size_mask

    function automatic logic [L2_IDX_W-1:0] l2_idx(input logic [31:0] va, input tlt_size_e sz);
        logic [31:0] t;
        t = va >> size_shift(sz);
        return t[L2_IDX_W-1:0];
    endfunction : l2_idx

    // full entry compare against request and current context
    function automatic logic tlb_match(input tlt_entry_s e, input tlt_req_s r,
                                       input logic [7:0] asid, input logic [7:0] vmid);
        logic va_ok;
        va_ok = ((r.va[31:SHIFT_4K] ^ e.vpn) & size_mask(e.d.size)) == '0;
        return e.valid && va_ok
            && (e.nonsecure_entry_tag == !r.secure) && (e.hyp == r.hyp)
            && (r.hyp || e.d.is_global || e.asid == asid)
            && (r.hyp || r.secure || e.vmid == vmid);
    endfunction : tlb_match

    // answer built from a matching entry, with permission and domain check
    function automatic tlt_resp_s make_resp(input tlt_entry_s e, input tlt_req_s r,
                                            input logic fetch, input tlt_ctrl_s ctl,
                                            input logic [31:0] dom);
        tlt_resp_s o;
        logic [1:0] da;
        logic [31:0] dsh;
        logic [VPN_W-1:0] m;
        m = size_mask(e.d.size);
        dsh = dom >> {e.d.domain, 1'b0};
        da = dsh[1:0];
        o.valid = 1'b1;
        o.pa = {(e.d.ppn & m) | (r.va[31:SHIFT_4K] & ~m), r.va[SHIFT_4K-1:0]};
        o.ns = e.d.ns;
        o.share = e.d.share;
        o.mtype = e.d.mtype;
        o.fault = FLT_NONE;
        if ((!r.priv && !e.d.ap_user) || (r.write && !e.d.ap_write) || (fetch && e.d.xn))
            o.fault = FLT_PERM;
        if (!ctl.long_descriptor_select && (da == 2'h0 || da == 2'h2))
            o.fault = FLT_DOMAIN;
        else if (!ctl.long_descriptor_select && da == 2'h3)
            o.fault = FLT_NONE;
        o.abort = o.fault != FLT_NONE;
        return o;
    endfunction : make_resp

    // next state
    always_comb
    begin
        next_s = s;
        for (int c = 0; c < NCH; c++)
            next_s.resp[c].valid = 1'b0;
        // register read, data stand in the following cycle only
        next_s.rdata = '0;
        if (reg_rd_in)
        begin
            case (reg_addr_in)
                OFS_CTRL_NS: next_s.rdata = 32'(s.ctrl_ns);
                OFS_CTRL_S: next_s.rdata = 32'(s.ctrl_s);
                OFS_CONTEXT: next_s.rdata = 32'(s.asid);
                OFS_STAGE2: next_s.rdata = 32'(s.vmid);
                OFS_DOMAIN: next_s.rdata = s.dom;
                OFS_FETCH_FSR: next_s.rdata = 32'(s.fetch_fsr);
                OFS_DATA_FSR: next_s.rdata = 32'(s.data_fsr);
                OFS_FLUSH: next_s.rdata = 32'(s.flush);
                default: next_s.rdata = '0;
            endcase
        end
        // register write; fault status cleared by any write to its offset
        if (reg_wr_in)
        begin
            case (reg_addr_in)
                OFS_CTRL_NS: next_s.ctrl_ns = tlt_ctrl_s'(reg_wdata_in[CTRL_W-1:0]);
                OFS_CTRL_S: next_s.ctrl_s = tlt_ctrl_s'(reg_wdata_in[CTRL_W-1:0]);
                OFS_CONTEXT: next_s.asid = reg_wdata_in[7:0];
                OFS_STAGE2: next_s.vmid = reg_wdata_in[7:0];
                OFS_DOMAIN: next_s.dom = reg_wdata_in;
                OFS_FETCH_FSR: next_s.fetch_fsr = '0;
                OFS_DATA_FSR: next_s.data_fsr = '0;
                OFS_FLUSH: next_s.flush = 1'b1;
                default: next_s.flush = s.flush;
            endcase
        end
        // first-level lookups, one per pipeline
        for (int c = 0; c < NCH; c++)
        begin
            l1_hit[c] = 1'b0;
            l1_e[c] = '0;
            for (int e = 0; e < L1_N; e++)
            begin
                if (tlb_match(s.l1[c][e], req_in[c], s.asid, s.vmid))
                begin
                    l1_hit[c] = 1'b1;
                    l1_e[c] = s.l1[c][e];
                end
            end
            if (req_valid_in[c] && s.ready[c])
            begin
                if (l1_hit[c])
                    next_s.resp[c] = make_resp(l1_e[c], req_in[c], c == CH_FETCH,
                        req_in[c].secure ? s.ctrl_s : s.ctrl_ns, s.dom);
                else
                begin
                    next_s.pend[c] = 1'b1;
                    next_s.ready[c] = 1'b0;
                    next_s.held[c] = req_in[c];
                end
            end
        end
        // second-level probe of the current size class
        cur = s.held[s.chan];
        cctl = cur.secure ? s.ctrl_s : s.ctrl_ns;
        pidx = l2_idx(cur.va, s.probe);
        l2_hit = 1'b0;
        l2_e = '0;
        for (int w = 0; w < L2_WAYS; w++)
        begin
            if (tlb_match(s.l2[pidx][w], cur, s.asid, s.vmid) && s.l2[pidx][w].d.size == s.probe)
            begin
                l2_hit = 1'b1;
                l2_e = s.l2[pidx][w];
            end
        end
        base1 = cctl.split && cur.va[31];
        if (cctl.long_descriptor_select)
            walk_off = base1 ? cctl.walk_disable_base1_long : cctl.walk_disable_base0_long;
        else
            walk_off = base1 ? cctl.walk_disable_base1_short : cctl.walk_disable_base0_short;
        // entry from a completed walk, tagged with the request context
        new_e.valid = 1'b1;
        new_e.vpn = cur.va[31:SHIFT_4K];
        new_e.d = walk_entry_in;
        new_e.asid = s.asid;
        new_e.vmid = s.vmid;
        new_e.nonsecure_entry_tag = !cur.secure;
        new_e.hyp = cur.hyp;
        fin = 1'b0;
        fin_fault = 1'b0;
        fin_e = '0;
        // shared second-level and walk sequencer
        case (s.st)
            ST_IDLE:
            begin
                if (s.flush)
                begin
                    // maintenance holds off every queued miss
                    for (int c = 0; c < NCH; c++)
                        for (int e = 0; e < L1_N; e++)
                            next_s.l1[c][e].valid = 1'b0;
                    for (int i = 0; i < L2_SETS; i++)
                        for (int w = 0; w < L2_WAYS; w++)
                            next_s.l2[i][w].valid = 1'b0;
                    next_s.flush = 1'b0;
                end
                else if (|s.pend)
                begin
                    // fixed priority: fetch, then load, then store
                    for (int c = NCH - 1; c >= 0; c--)
                        if (s.pend[c])
                            next_s.chan = CH_W'(c);
                    next_s.probe = SZ_4K;
                    next_s.st = ST_PROBE;
                end
            end
            ST_PROBE:
            begin
                if (l2_hit)
                begin
                    fin = 1'b1;
                    fin_e = l2_e;
                end
                else if (s.probe == SZ_1G)
                begin
                    if (walk_off)
                    begin
                        fin = 1'b1;
                        fin_fault = 1'b1;
                    end
                    else
                    begin
                        next_s.walk_req = 1'b1;
                        next_s.walk_va = cur.va;
                        next_s.walk_cached = cctl.walk_inner_cacheability[0];
                        next_s.walk_long = cctl.long_descriptor_select;
                        next_s.walk_base1 = base1;
                        next_s.st = ST_WALK;
                    end
                end
                else
                    next_s.probe = tlt_size_e'(s.probe + 3'h1);
            end
            ST_WALK:
            begin
                if (walk_done_in)
                begin
                    next_s.walk_req = 1'b0;
                    fin = 1'b1;
                    fin_fault = walk_fault_in;
                    fin_e = new_e;
                    if (!walk_fault_in)
                    begin
                        // round-robin victim, nothing is ever pinned
                        next_s.l2[l2_idx(cur.va, new_e.d.size)][s.victim] = new_e;
                        next_s.victim = L2_WAY_W'(s.victim + 2'h1);
                    end
                end
            end
            default: next_s.st = ST_IDLE;
        endcase
        // finish: answer the requester and refill its first level
        fin_r = make_resp(fin_e, cur, s.chan == CH_W'(CH_FETCH), cctl, s.dom);
        if (fin_fault)
        begin
            fin_r = '0;
            fin_r.valid = 1'b1;
            fin_r.abort = 1'b1;
            fin_r.fault = FLT_TRANS;
        end
        if (fin)
        begin
            next_s.st = ST_IDLE;
            next_s.resp[s.chan] = fin_r;
            next_s.pend[s.chan] = 1'b0;
            next_s.ready[s.chan] = 1'b1;
            if (!fin_fault)
            begin
                // one 4K slice of a larger page, tags kept
                fin_e.vpn = cur.va[31:SHIFT_4K];
                fin_e.d.ppn = fin_r.pa[31:SHIFT_4K];
                fin_e.d.size = SZ_4K;
                next_s.l1[s.chan][s.l1_ptr[s.chan]] = fin_e;
                next_s.l1_ptr[s.chan] = L1_IDX_W'(s.l1_ptr[s.chan] + 5'h1);
            end
        end
        // fault status capture, set wins over a same-cycle clear
        for (int c = 0; c < NCH; c++)
        begin
            if (next_s.resp[c].valid && next_s.resp[c].abort)
            begin
                if (c == CH_FETCH)
                    next_s.fetch_fsr = {1'b1, next_s.resp[c].fault};
                else
                    next_s.data_fsr = {1'b1, next_s.resp[c].fault};
            end
        end
        if (!rst_b_in)
        begin
            next_s = '0;
            next_s.st = ST_IDLE;
            next_s.ready = '1;
        end
    end

    // state register
    always_ff @(posedge clk_in)
    begin
        s <= next_s;
    end

    // outputs straight from state
    assign req_ready_out = s.ready;
    assign resp_out = s.resp;
    assign walk_req_out = s.walk_req;
    assign walk_va_out = s.walk_va;
    assign walk_cached_out = s.walk_cached;
    assign walk_long_out = s.walk_long;
    assign walk_base1_out = s.walk_base1;
    assign reg_rdata_out = s.rdata;

    // fetch hit gives a valid answer in the next cycle
    fetch_hit_time_a: assert property (
        req_valid_in[0] && req_ready_out[0] && l1_hit[0] |=> resp_out[0].valid)
        else $error("fetch hit not answered next cycle");
    // load hit keeps the page offset
    load_hit_offset_a: assert property (
        req_valid_in[1] && req_ready_out[1] && l1_hit[1]
        |=> resp_out[1].valid && resp_out[1].pa[11:0] == $past(req_in[1].va[11:0]))
        else $error("load hit answer wrong or late");
    // a store miss goes pending and drops ready
    miss_pending_a: assert property (
        req_valid_in[2] && req_ready_out[2] && !l1_hit[2] |=> !req_ready_out[2] && s.pend[2])
        else $error("store miss not queued");
    // walk only after the last size class missed
    walk_after_miss_a: assert property (
        $rose(walk_req_out) |-> $past(s.st == ST_PROBE) && $past(s.probe == SZ_1G) && !$past(l2_hit))
        else $error("walk started without second-level miss");
    // disabled walk answers a translation fault, never walks
    walk_disabled_a: assert property (
        s.st == ST_PROBE && s.probe == SZ_1G && !l2_hit && walk_off
        |=> !walk_req_out && resp_out[$past(s.chan)].fault == FLT_TRANS)
        else $error("disabled walk not faulted");
    // walk path choice follows cacheability of the request state
    walk_path_a: assert property (
        $rose(walk_req_out) |-> walk_cached_out == $past(cctl.walk_inner_cacheability[0])
        && walk_long_out == $past(cctl.long_descriptor_select))
        else $error("walk path or format wrong");
    // refill into fetch first level is always a 4K entry
    refill_small_a: assert property (
        fin && !fin_fault && s.chan == 2'h0
        |=> s.l1[0][$past(s.l1_ptr[0])].d.size == SZ_4K && s.l1[0][$past(s.l1_ptr[0])].valid)
        else $error("refill not a valid 4K entry");
    // fetch answer: abort only with a fault code
    abort_code_a: assert property (
        resp_out[0].valid |-> resp_out[0].abort == (resp_out[0].fault != FLT_NONE))
        else $error("abort and fault code disagree");
    // walk request held until done
    walk_hold_a: assert property (
        walk_req_out && !walk_done_in |=> walk_req_out)
        else $error("walk request dropped early");
endmodule : tlt_translate

// ---- logic/tlt_pkg.sv ----
package tlt_pkg;
    // structure sizes
    localparam int NCH = 3;
    localparam int CH_W = 2;
    localparam int L1_N = 32;
    localparam int L1_IDX_W = 5;
    localparam int L2_SETS = 128;
    localparam int L2_IDX_W = 7;
    localparam int L2_WAYS = 4;
    localparam int L2_WAY_W = 2;
    localparam int VPN_W = 20;
    localparam int CTRL_W = 8;
    localparam int FSR_W = 5;
    localparam int CH_FETCH = 0;
    // page shifts, log2 of each page size
    localparam logic [4:0] SHIFT_4K = 5'h0C;
    localparam logic [4:0] SHIFT_64K = 5'h10;
    localparam logic [4:0] SHIFT_1M = 5'h14;
    localparam logic [4:0] SHIFT_2M = 5'h15;
    localparam logic [4:0] SHIFT_16M = 5'h18;
    localparam logic [4:0] SHIFT_1G = 5'h1E;
    // register offsets
    localparam logic [7:0] OFS_CTRL_NS = 8'h00;
    localparam logic [7:0] OFS_CTRL_S = 8'h04;
    localparam logic [7:0] OFS_CONTEXT = 8'h08;
    localparam logic [7:0] OFS_STAGE2 = 8'h0C;
    localparam logic [7:0] OFS_DOMAIN = 8'h10;
    localparam logic [7:0] OFS_FETCH_FSR = 8'h14;
    localparam logic [7:0] OFS_DATA_FSR = 8'h18;
    localparam logic [7:0] OFS_FLUSH = 8'h1C;
    // fault codes
    localparam logic [3:0] FLT_NONE = 4'h0;
    localparam logic [3:0] FLT_TRANS = 4'h5;
    localparam logic [3:0] FLT_DOMAIN = 4'h9;
    localparam logic [3:0] FLT_PERM = 4'hD;

    typedef enum logic [2:0] {
        SZ_4K = 3'h0, SZ_64K = 3'h1, SZ_1M = 3'h2, SZ_2M = 3'h3, SZ_16M = 3'h4, SZ_1G = 3'h5
    } tlt_size_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1, ST_PROBE = 3'h2, ST_WALK = 3'h4
    } tlt_state_e;

    typedef struct packed {
        logic split;
        logic [1:0] walk_inner_cacheability;
        logic walk_disable_base1_long;
        logic walk_disable_base0_long;
        logic walk_disable_base1_short;
        logic walk_disable_base0_short;
        logic long_descriptor_select;
    } tlt_ctrl_s;

    typedef struct packed {
        logic [31:0] va;
        logic write;
        logic priv;
        logic secure;
        logic hyp;
    } tlt_req_s;

    typedef struct packed {
        logic valid;
        logic abort;
        logic [3:0] fault;
        logic [31:0] pa;
        logic ns;
        logic [1:0] share;
        logic [1:0] mtype;
    } tlt_resp_s;

    typedef struct packed {
        logic [VPN_W-1:0] ppn;
        tlt_size_e size;
        logic ap_user;
        logic ap_write;
        logic xn;
        logic [3:0] domain;
        logic ns;
        logic [1:0] share;
        logic [1:0] mtype;
        logic is_global;
    } tlt_walk_s;

    typedef struct packed {
        logic valid;
        logic [VPN_W-1:0] vpn;
        tlt_walk_s d;
        logic [7:0] asid;
        logic [7:0] vmid;
        logic nonsecure_entry_tag;
        logic hyp;
    } tlt_entry_s;

    typedef struct packed {
        tlt_state_e st;
        tlt_entry_s [NCH-1:0][L1_N-1:0] l1;
        tlt_entry_s [L2_SETS-1:0][L2_WAYS-1:0] l2;
        logic [NCH-1:0][L1_IDX_W-1:0] l1_ptr;
        logic [L2_WAY_W-1:0] victim;
        logic [NCH-1:0] pend;
        logic [NCH-1:0] ready;
        tlt_req_s [NCH-1:0] held;
        logic [CH_W-1:0] chan;
        tlt_size_e probe;
        tlt_resp_s [NCH-1:0] resp;
        logic walk_req;
        logic walk_cached;
        logic walk_long;
        logic walk_base1;
        logic [31:0] walk_va;
        tlt_ctrl_s ctrl_ns;
        tlt_ctrl_s ctrl_s;
        logic [7:0] asid;
        logic [7:0] vmid;
        logic [31:0] dom;
        logic [FSR_W-1:0] fetch_fsr;
        logic [FSR_W-1:0] data_fsr;
        logic flush;
        logic [31:0] rdata;
    } tlt_state_s;
endpackage : tlt_pkg

// ---- testbench/tlt_walker_model.sv ----
`timescale 1ns/100ps
module tlt_walker_model
    import tlt_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic walk_req_in,
    input wire logic [3:0] delay_in,
    input wire tlt_walk_s entry_cfg_in,
    input wire logic fault_cfg_in,
    output logic walk_done_out,
    output logic walk_fault_out,
    output tlt_walk_s walk_entry_out,
    output logic [7:0] walk_count_out
);
    logic busy;
    logic [3:0] cnt;
    // descriptor only valid with done, inverted pattern otherwise
    assign walk_entry_out = walk_done_out ? entry_cfg_in : ~entry_cfg_in;
    // fault flag only meaningful with done
    assign walk_fault_out = walk_done_out & fault_cfg_in;
    // one walk at a time, answered after a programmable delay
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            busy <= 1'b0;
            cnt <= 4'h0;
            walk_done_out <= 1'b0;
            walk_count_out <= 8'h00;
        end
        else if (walk_done_out)
            walk_done_out <= 1'b0;
        else if (busy && !walk_req_in)
            busy <= 1'b0;
        else if (!busy && walk_req_in)
        begin
            busy <= 1'b1;
            cnt <= delay_in;
            walk_count_out <= walk_count_out + 8'h01;
        end
        else if (busy && cnt != 4'h0)
            cnt <= cnt - 4'h1;
        else if (busy)
            walk_done_out <= 1'b1;
    end
endmodule : tlt_walker_model

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
module testbench;
    import tlt_pkg::*;
    logic clk_in = 1'b0, rst_b_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic [NCH-1:0] req_valid_in = '0, req_ready_out;
    tlt_req_s [NCH-1:0] req_in = '0;
    tlt_resp_s [NCH-1:0] resp_out;
    logic walk_req_out, walk_cached_out, walk_long_out, walk_base1_out, walk_done_in, walk_fault_in;
    logic [31:0] walk_va_out, reg_wdata_in = '0, reg_rdata_out, wva;
    logic [7:0] reg_addr_in = '0, n_walks;
    tlt_walk_s walk_entry_in, cfg = '0;
    logic wlong, wcached, wfault = 1'b0;
    int n_fail = 0, num_checks = 0, lat;
    tlt_resp_s r;
    always #2.5 clk_in = ~clk_in;
    tlt_translate dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .req_valid_in(req_valid_in),
        .req_in(req_in), .req_ready_out(req_ready_out), .resp_out(resp_out),
        .walk_req_out(walk_req_out), .walk_va_out(walk_va_out), .walk_cached_out(walk_cached_out),
        .walk_long_out(walk_long_out), .walk_base1_out(walk_base1_out),
        .walk_done_in(walk_done_in), .walk_fault_in(walk_fault_in), .walk_entry_in(walk_entry_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out));
    tlt_walker_model walker (.clk_in(clk_in), .rst_b_in(rst_b_in), .walk_req_in(walk_req_out),
        .delay_in(4'h3), .entry_cfg_in(cfg), .fault_cfg_in(wfault), .walk_done_out(walk_done_in),
        .walk_fault_out(walk_fault_in), .walk_entry_out(walk_entry_in), .walk_count_out(n_walks));
    // capture the walk port while a walk is open
    always @(posedge clk_in)
        if (walk_req_out)
            {wva, wlong, wcached} <= {walk_va_out, walk_long_out, walk_cached_out};
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'b1};
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : reg_wr
    task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        {reg_addr_in, reg_rd_in} <= {a, 1'b1};
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 chk(reg_rdata_out, exp, "register read");
    endtask : reg_chk
    // one request on a channel, waits for the answer and counts cycles
    task automatic req(input int ch, input logic [31:0] va, input logic wr, input logic hyp);
        for (int i = 0; !req_ready_out[ch]; i++)
        begin
            if (i > 50)
            begin
                n_fail++;
                finish_test();
            end
            @(posedge clk_in);
            #1;
        end
        @(posedge clk_in);
        req_valid_in[ch] <= 1'b1;
        req_in[ch] <= '{va: va, write: wr, priv: 1'b1, secure: 1'b0, hyp: hyp};
        @(posedge clk_in);
        req_valid_in[ch] <= 1'b0;
        for (lat = 1; lat < 100; lat++)
        begin
            #1;
            if (resp_out[ch].valid === 1'b1)
                break;
            @(posedge clk_in);
        end
        r = resp_out[ch];
        if (lat >= 100)
        begin
            n_fail++;
            finish_test();
        end
    endtask : req
    task automatic t_regs();
        reg_wr(OFS_CTRL_NS, 32'h00000021);
        reg_chk(OFS_CTRL_NS, 32'h00000021);
        reg_chk(8'hF0, 32'h00000000);
        $display("test registers done");
    endtask : t_regs
    task automatic t_walk();
        cfg = '{ppn: 20'hABCDE, size: SZ_4K, ap_user: 1'b1, ap_write: 1'b1, xn: 1'b0,
            domain: 4'h0, ns: 1'b1, share: 2'h2, mtype: 2'h1, is_global: 1'b0};
        req(CH_FETCH, 32'h12345678, 1'b0, 1'b0);
        chk(r, {1'b1, 1'b0, FLT_NONE, 32'hABCDE678, 1'b1, 2'h2, 2'h1}, "walk resp");
        chk({n_walks, wva, wlong, wcached}, {8'h01, 32'h12345678, 2'b11}, "walk port");
        req(CH_FETCH, 32'h12345ABC, 1'b0, 1'b0);
        chk({lat[7:0], r.pa, n_walks}, {8'h01, 32'hABCDEABC, 8'h01}, "fetch hit");
        req(CH_FETCH, 32'h12345ABC, 1'b0, 1'b1);
        chk(n_walks, 8'h02, "hyp request must miss");
        $display("test walk done");
    endtask : t_walk
    task automatic t_big();
        cfg.size = SZ_1M;
        cfg.ppn = 20'hA0000;
        req(1, 32'h00512345, 1'b0, 1'b0);
        chk({r.abort, r.pa, n_walks}, {1'b0, 32'hA0012345, 8'h03}, "1M walk");
        req(1, 32'h00512ABC, 1'b0, 1'b0);
        chk({lat[7:0], r.pa}, {8'h01, 32'hA0012ABC}, "load hit");
        req(2, 32'h005FF010, 1'b1, 1'b0);
        chk({r.pa, n_walks}, {32'hA00FF010, 8'h03}, "second level hit");
        req(1, 32'h00500010, 1'b0, 1'b0);
        chk({lat > 1, r.pa, n_walks}, {1'b1, 32'hA0000010, 8'h03}, "other 4K refetch");
        $display("test large page done");
    endtask : t_big
    task automatic t_faults();
        cfg.size = SZ_4K;
        cfg.ap_write = 1'b0;
        req(2, 32'h30000100, 1'b1, 1'b0);
        chk({r.abort, r.fault}, {1'b1, FLT_PERM}, "store permission");
        reg_wr(OFS_DATA_FSR, 32'h00000000);
        reg_wr(OFS_CTRL_NS, 32'h00000009);
        req(1, 32'h40000000, 1'b0, 1'b0);
        chk({r.abort, r.fault, n_walks}, {1'b1, FLT_TRANS, 8'h04}, "walk disabled");
        reg_chk(OFS_DATA_FSR, 32'h00000015);
        // short format, domain 0 has no access: a hit must fault
        reg_wr(OFS_CTRL_NS, 32'h00000000);
        req(CH_FETCH, 32'h12345ABC, 1'b0, 1'b0);
        chk({lat[7:0], r.abort, r.fault}, {8'h01, 1'b1, FLT_DOMAIN}, "hit domain");
        reg_chk(OFS_FETCH_FSR, 32'h00000019);
        // walker reports a fault, walk read goes external
        wfault = 1'b1;
        req(CH_FETCH, 32'h50000000, 1'b0, 1'b0);
        chk({r.abort, r.fault, wcached}, {1'b1, FLT_TRANS, 1'b0}, "walk fault");
        $display("test faults done");
    endtask : t_faults
    // reset, scenarios, verdict
    initial
    begin
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_regs();
        t_walk();
        t_big();
        t_faults();
        finish_test();
    end
endmodule : testbench
